// ### als_pkg.sv
// ==========================================
// Shared constants of the L1 enable sequencer
// ==========================================
package als_pkg;
	// Standard config constants; the OFS_ offsets are relative to the PCIe capability
	localparam logic [7:0]  CAP_PTR_OFS = 8'h34;      // Head of the capability list
	localparam logic [7:0]  CAP_ID_PCIE = 8'h10;      // PCIe capability identifier
	localparam logic [7:0]  OFS_DEVCAP  = 8'h04;      // Function ability word
	localparam logic [7:0]  OFS_LCAP    = 8'h0c;      // Port ability word
	localparam logic [7:0]  OFS_LCTL    = 8'h10;      // Port control word
	localparam logic [7:0]  PTR_MASK    = 8'hfc;      // Capability pointers are dword aligned
	// Root port registers, absolute offsets
	localparam logic [11:0] ROOT_LCTL   = 12'h068;    // Root port_control_word
	localparam logic [11:0] ROOT_LCAP   = 12'h064;    // Root port_ability_word
	// Field positions
	localparam int          SUP_BIT     = 11;         // low_power_support_bit
	localparam int          EXIT_LSB    = 15;         // wake_delay_code, 3 bits
	localparam int          TOL_LSB     = 9;          // tolerated_wake_delay, 3 bits
	localparam logic [31:0] ENA_MASK    = 32'h0000_0002; // power_state_enable_field bit 1
	// Latency figures in microseconds
	localparam int          BASE_US     = 4;
	localparam int          HOP_US      = 1;
	// Guard against a looped capability list
	localparam logic [5:0]  MAX_HOPS    = 6'h30;
	localparam logic [3:0]  PAR_ROOT    = 4'hf;       // Parent code for the root port
	// Wishbone register word indices (byte offset / 4)
	localparam logic [5:0]  REG_CTRL    = 6'h00;
	localparam logic [5:0]  REG_STAT    = 6'h01;
	localparam logic [5:0]  REG_ROOT    = 6'h02;
	localparam logic [5:0]  REG_SEL     = 6'h03;
	localparam logic [5:0]  REG_DCFG    = 6'h04;
	localparam logic [5:0]  REG_DRES    = 6'h05;
	// Reset value of software registers
	localparam logic [31:0] REG_RST     = 32'h0000_0000;
	// Outcome of a run
	typedef enum logic [2:0] {RES_NONE, RES_FULL, RES_LINKS, RES_NOEP, RES_LAT} als_res_t;
endpackage : als_pkg

// ### als_wb_slave.sv
`timescale 1ns/100ps
// ==========================================
// Classic Wishbone slave front end
// ==========================================
module als_wb_slave (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Wishbone
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Register file side
	input  wire logic [31:0] rd_data_i,
	output logic      [5:0]  idx_o,
	output logic             wr_fire_o,
	output logic      [31:0] wr_data_o
);
	logic        take;       // New access this cycle
	logic        ack_q;      // Ack flop
	logic        ack_d;
	logic [31:0] dat_q;      // Read data flop
	logic [31:0] dat_d;

	// Ack is blocked for one cycle so each request is taken once
	assign take      = wb_cyc_i && wb_stb_i && !ack_q;
	assign idx_o     = wb_adr_i[7:2];
	assign wr_fire_o = take && wb_we_i;
	assign wr_data_o = wb_dat_i;
	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = dat_q;

	// Next answer
	always_comb
	begin
		ack_d = take;
		dat_d = dat_q;
		if (take && !wb_we_i)
			dat_d = rd_data_i;
	end

	// Answer registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			dat_q <= als_pkg::REG_RST;
		end
		else
		begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end
endmodule : als_wb_slave

// ### als_cfg_master.sv
`timescale 1ns/100ps
// ==========================================
// Single outstanding configuration access
// ==========================================
module als_cfg_master (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Request from the sequencer
	input  wire logic        go_i,
	input  wire logic        we_i,
	input  wire logic [15:0] tgt_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic             done_o,
	output logic      [31:0] rdata_o,
	// Configuration port
	output logic             cfg_req_o,
	output logic             cfg_we_o,
	output logic      [15:0] cfg_tgt_o,
	output logic      [11:0] cfg_addr_o,
	output logic      [31:0] cfg_wdata_o,
	input  wire logic        cfg_ack_i,
	input  wire logic [31:0] cfg_rdata_i
);
	logic        req_q, req_d;       // Access in flight
	logic        we_q, we_d;
	logic [15:0] tgt_q, tgt_d;
	logic [11:0] adr_q, adr_d;
	logic [31:0] wd_q, wd_d;
	logic        done_q, done_d;     // One-cycle completion pulse
	logic [31:0] rd_q, rd_d;         // Last read data, held until next ack

	assign cfg_req_o   = req_q;
	assign cfg_we_o    = we_q;
	assign cfg_tgt_o   = tgt_q;
	assign cfg_addr_o  = adr_q;
	assign cfg_wdata_o = wd_q;
	assign done_o      = done_q;
	assign rdata_o     = rd_q;

	// Launch, hold until ack, then report
	always_comb
	begin
		req_d  = req_q;
		we_d   = we_q;
		tgt_d  = tgt_q;
		adr_d  = adr_q;
		wd_d   = wd_q;
		done_d = 1'b0;
		rd_d   = rd_q;
		if (!req_q && go_i)
		begin
			req_d = 1'b1;
			we_d  = we_i;
			tgt_d = tgt_i;
			adr_d = addr_i;
			wd_d  = wdata_i;
		end
		else if (req_q && cfg_ack_i)
		begin
			// Read data captured only on the completion itself [RULE_14]
			req_d  = 1'b0;
			done_d = 1'b1;
			rd_d   = cfg_rdata_i;
		end
	end

	// Access registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			req_q  <= 1'b0;
			we_q   <= 1'b0;
			tgt_q  <= 16'h0000;
			adr_q  <= 12'h000;
			wd_q   <= 32'h0000_0000;
			done_q <= 1'b0;
			rd_q   <= 32'h0000_0000;
		end
		else
		begin
			req_q  <= req_d;
			we_q   <= we_d;
			tgt_q  <= tgt_d;
			adr_q  <= adr_d;
			wd_q   <= wd_d;
			done_q <= done_d;
			rd_q   <= rd_d;
		end
	end
endmodule : als_cfg_master

// ### als_l1_seq.sv
// What this block does
// [RULE_01] Blacklisted device: find capability, clear enable bit
// [RULE_02] Read support bit 11 of every ability word; blacklisted entries are not read
// [RULE_03] Unsupporting switch below root: go per-link enable
// [RULE_04] Supporting switch below root: evaluate exit latency
// [RULE_05] Endpoint below root: abort unless support set
// [RULE_06] Read each endpoint's three-bit wake delay code; blacklisted entries are not read
// [RULE_07] Effective delay is 4us plus 1us per hop
// [RULE_08] Read tolerated delay, bits 11:9 at offset 4
// [RULE_09] Tolerated below effective ends run, nothing enabled
// [RULE_10] Set bit 1 of root control at 0x68
// [RULE_11] Enable every link whose both ends support it
// [RULE_12] Root port advertises support and exit latency
// [RULE_13] Enabled idle link goes to electrical idle
// [RULE_14] One access at a time, branch after completion
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
// ==========================================
// L1 enable sequencer, top
// ==========================================
module als_l1_seq #(
	parameter int NDEV = 4                   // Hierarchy table entries, at most 15
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Configuration access port
	output logic             cfg_req_o,
	output logic             cfg_we_o,
	output logic      [15:0] cfg_tgt_o,
	output logic      [11:0] cfg_addr_o,
	output logic      [31:0] cfg_wdata_o,
	input  wire logic        cfg_ack_i,
	input  wire logic [31:0] cfg_rdata_i
);
	localparam int IW = (NDEV > 1) ? $clog2(NDEV) : 1;

	typedef enum logic [3:0] {S_IDLE, S_RCAP, S_PTR, S_WALK, S_BLRD, S_BLWR, S_LCAP,
		S_DECIDE, S_DCAP, S_RRD, S_RWR, S_LRD, S_LWR} als_st_t;

	// ==========================================
	// Helpers
	// ==========================================
	// Byte-lane merge of a Wishbone write
	function automatic logic [31:0] als_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction : als_merge

	// Tolerated delay code to microseconds, 7 means no limit
	function automatic logic [7:0] als_tol_us(input logic [2:0] c);
		return (c == 3'h7) ? 8'hff : (8'h01 << c);
	endfunction : als_tol_us

	// Effective delay for an endpoint this many links below the root
	function automatic logic [7:0] als_eff_us(input logic [3:0] dep);
		return 8'(als_pkg::BASE_US) + ({4'h0, dep} - 8'h01) * 8'(als_pkg::HOP_US); // [RULE_07]
	endfunction : als_eff_us

	// ==========================================
	// Bus and access engines
	// ==========================================
	logic [31:0] rd_mux;        // Register read value for the addressed word
	logic [5:0]  widx;          // Word index of the access
	logic        wr_fire;       // Write taken this cycle
	logic [31:0] wr_data;
	logic        go;            // Launch a configuration access
	logic        acc_we;
	logic [15:0] acc_tgt;
	logic [11:0] acc_adr;
	logic [31:0] acc_wd;
	logic        cdone;         // Access completed, rdat valid
	logic [31:0] rdat;

	als_wb_slave u_wb (
		.mclk      (mclk),
		.rst       (rst),
		.wb_cyc_i  (wb_cyc_i),
		.wb_stb_i  (wb_stb_i),
		.wb_we_i   (wb_we_i),
		.wb_adr_i  (wb_adr_i),
		.wb_dat_i  (wb_dat_i),
		.wb_dat_o  (wb_dat_o),
		.wb_ack_o  (wb_ack_o),
		.rd_data_i (rd_mux),
		.idx_o     (widx),
		.wr_fire_o (wr_fire),
		.wr_data_o (wr_data)
	);

	als_cfg_master u_cfg (
		.mclk        (mclk),
		.rst         (rst),
		.go_i        (go),
		.we_i        (acc_we),
		.tgt_i       (acc_tgt),
		.addr_i      (acc_adr),
		.wdata_i     (acc_wd),
		.done_o      (cdone),
		.rdata_o     (rdat),
		.cfg_req_o   (cfg_req_o),
		.cfg_we_o    (cfg_we_o),
		.cfg_tgt_o   (cfg_tgt_o),
		.cfg_addr_o  (cfg_addr_o),
		.cfg_wdata_o (cfg_wdata_o),
		.cfg_ack_i   (cfg_ack_i),
		.cfg_rdata_i (cfg_rdata_i)
	);

	// ==========================================
	// Software table
	// ==========================================
	logic [15:0]   root_q, root_d;           // Root port target id
	logic [IW-1:0] sel_q, sel_d;             // Entry picked for table access
	logic [15:0]   tgt_q [NDEV];             // Entry target id
	logic [15:0]   tgt_d [NDEV];
	logic [3:0]    par_q [NDEV];             // Upstream entry, PAR_ROOT for the root
	logic [3:0]    par_d [NDEV];
	logic [3:0]    dep_q [NDEV];             // Links between entry and root
	logic [3:0]    dep_d [NDEV];
	logic          sw_q  [NDEV];             // Entry is a switch port
	logic          sw_d  [NDEV];
	logic          bl_q  [NDEV];             // Entry on the incompatible list
	logic          bl_d  [NDEV];
	logic          vld_q [NDEV];             // Entry in use
	logic          vld_d [NDEV];
	logic          start;                    // Start pulse from software
	logic          busy;
	als_st_t       st_q, st_d;

	assign busy  = (st_q != S_IDLE);
	assign start = wr_fire && (widx == als_pkg::REG_CTRL) && wb_sel_i[0] && wr_data[0];

	// Table writes; refused while a run is going so it sees a stable table
	always_comb
	begin
		logic [31:0] w;
		w      = 32'h0000_0000;
		root_d = root_q;
		sel_d  = sel_q;
		tgt_d  = tgt_q;
		par_d  = par_q;
		dep_d  = dep_q;
		sw_d   = sw_q;
		bl_d   = bl_q;
		vld_d  = vld_q;
		if (wr_fire && !busy)
		begin
			case (widx)
				als_pkg::REG_ROOT:
				begin
					w      = als_merge({16'h0000, root_q}, wr_data, wb_sel_i);
					root_d = w[15:0];
				end
				als_pkg::REG_SEL:
				begin
					w     = als_merge({{(32-IW){1'b0}}, sel_q}, wr_data, wb_sel_i);
					sel_d = w[IW-1:0];
				end
				als_pkg::REG_DCFG:
				begin
					w = als_merge({4'h0, dep_q[sel_q], 1'b0, vld_q[sel_q], bl_q[sel_q],
						sw_q[sel_q], par_q[sel_q], tgt_q[sel_q]}, wr_data, wb_sel_i);
					tgt_d[sel_q] = w[15:0];
					par_d[sel_q] = w[19:16];
					sw_d[sel_q]  = w[20];
					bl_d[sel_q]  = w[21];
					vld_d[sel_q] = w[22];
					dep_d[sel_q] = w[27:24];
				end
				default:
				begin
					// Control, unmapped or read-only word: no table write
				end
			endcase
		end
	end

	// Table registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			root_q <= 16'h0000;
			sel_q  <= '0;
			for (int i = 0; i < NDEV; i++)
			begin
				tgt_q[i] <= 16'h0000;
				par_q[i] <= als_pkg::PAR_ROOT;
				dep_q[i] <= 4'h1;
				sw_q[i]  <= 1'b0;
				bl_q[i]  <= 1'b0;
				vld_q[i] <= 1'b0;
			end
		end
		else
		begin
			root_q <= root_d;
			sel_q  <= sel_d;
			tgt_q  <= tgt_d;
			par_q  <= par_d;
			dep_q  <= dep_d;
			sw_q   <= sw_d;
			bl_q   <= bl_d;
			vld_q  <= vld_d;
		end
	end

	// ==========================================
	// Sequencer
	// ==========================================
	logic [IW-1:0]      idx_q, idx_d;        // Entry being worked on
	logic [7:0]         ptr_q, ptr_d;        // Capability list cursor
	logic [5:0]         hop_q, hop_d;        // List steps taken
	logic               iss_q, iss_d;        // Access in flight
	logic               rsup_q, rsup_d;      // Root advertises support
	als_pkg::als_res_t  res_q, res_d;
	logic [7:0]         cap_q [NDEV];        // PCIe capability pointer per entry
	logic [7:0]         cap_d [NDEV];
	logic               cok_q [NDEV];        // Capability found
	logic               cok_d [NDEV];
	logic               sup_q [NDEV];        // Support bit as read
	logic               sup_d [NDEV];
	logic               en_q  [NDEV];        // Link enable written
	logic               en_d  [NDEV];
	logic [2:0]         ext_q [NDEV];        // Wake delay code
	logic [2:0]         ext_d [NDEV];
	logic [2:0]         tol_q [NDEV];        // Tolerated delay code
	logic [2:0]         tol_d [NDEV];
	logic               last, psup, el, acc;
	logic [7:0]         nxt;
	logic [7:0]         cap;

	assign last = (idx_q == IW'(NDEV - 1));
	assign cap  = cap_q[idx_q];
	assign nxt  = rdat[15:8] & als_pkg::PTR_MASK;
	// Upstream end of this entry's link
	assign psup = (par_q[idx_q] == als_pkg::PAR_ROOT) ? rsup_q :
		(par_q[idx_q] < 4'(NDEV)) ? sup_q[par_q[idx_q][IW-1:0]] : 1'b0;

	// Access descriptor, eligibility and next state
	always_comb
	begin
		st_d   = st_q;
		idx_d  = idx_q;
		ptr_d  = ptr_q;
		hop_d  = hop_q;
		iss_d  = iss_q;
		rsup_d = rsup_q;
		res_d  = res_q;
		cap_d  = cap_q;
		cok_d  = cok_q;
		sup_d  = sup_q;
		en_d   = en_q;
		ext_d  = ext_q;
		tol_d  = tol_q;
		acc    = 1'b1;
		el     = vld_q[idx_q];
		acc_we = 1'b0;
		acc_tgt = tgt_q[idx_q];
		acc_wd = 32'h0000_0000;
		acc_adr = {4'h0, cap + als_pkg::OFS_LCTL};
		case (st_q)
			S_RCAP, S_RRD: begin acc_tgt = root_q; el = 1'b1;
				acc_adr = (st_q == S_RCAP) ? als_pkg::ROOT_LCAP : als_pkg::ROOT_LCTL; end
			S_RWR: begin acc_tgt = root_q; el = 1'b1; acc_we = 1'b1;
				acc_adr = als_pkg::ROOT_LCTL; acc_wd = rdat | als_pkg::ENA_MASK; end  // [RULE_10]
			S_PTR: acc_adr = {4'h0, als_pkg::CAP_PTR_OFS};
			S_WALK: acc_adr = {4'h0, ptr_q};
			S_BLWR: begin acc_we = 1'b1; acc_wd = rdat & ~als_pkg::ENA_MASK; end  // [RULE_01]
			S_LCAP: acc_adr = {4'h0, cap + als_pkg::OFS_LCAP};
			S_DCAP: begin acc_adr = {4'h0, cap + als_pkg::OFS_DEVCAP};
				el = vld_q[idx_q] && !sw_q[idx_q] && !bl_q[idx_q] && cok_q[idx_q]; end
			S_LRD: el = vld_q[idx_q] && !bl_q[idx_q] && sup_q[idx_q] && psup;  // [RULE_11]
			S_LWR: begin acc_we = 1'b1; acc_wd = rdat | als_pkg::ENA_MASK; end  // [RULE_11]
			S_BLRD: ;
			default: begin acc = 1'b0; el = 1'b0; end
		endcase
		// One access at a time, launched only when none is pending [RULE_14]
		go = acc && el && !iss_q;
		if (go)
			iss_d = 1'b1;
		if (cdone)
			iss_d = 1'b0;

		case (st_q)
			S_IDLE:
				if (start)
				begin
					idx_d = '0;
					res_d = als_pkg::RES_NONE;
					for (int i = 0; i < NDEV; i++)
					begin
						cok_d[i] = 1'b0;
						sup_d[i] = 1'b0;
						en_d[i]  = 1'b0;
					end
					st_d = S_RCAP;
				end
			S_RCAP:
				if (cdone)
				begin
					rsup_d = rdat[als_pkg::SUP_BIT];
					st_d   = S_PTR;
				end
			S_PTR:
				// Skip unused entries; a zero list head means no capability
				if (!el || (cdone && (rdat[7:0] & als_pkg::PTR_MASK) == 8'h00))
				begin
					idx_d = last ? idx_q : idx_q + IW'(1);
					st_d  = last ? S_DECIDE : S_PTR;
				end
				else if (cdone)
				begin
					ptr_d = rdat[7:0] & als_pkg::PTR_MASK;
					hop_d = 6'h00;
					st_d  = S_WALK;
				end
			S_WALK:
				if (cdone)
				begin
					if (rdat[7:0] == als_pkg::CAP_ID_PCIE)
					begin
						// Capability located by walking the list [RULE_01]
						cap_d[idx_q] = ptr_q;
						cok_d[idx_q] = 1'b1;
						st_d = bl_q[idx_q] ? S_BLRD : S_LCAP;
					end
					else if (nxt == 8'h00 || hop_q == als_pkg::MAX_HOPS)
					begin
						// End of list or a looped list: entry stays unsupported
						idx_d = last ? idx_q : idx_q + IW'(1);
						st_d  = last ? S_DECIDE : S_PTR;
					end
					else
					begin
						ptr_d = nxt;
						hop_d = hop_q + 6'h01;
					end
				end
			S_BLRD:
				if (cdone)
					st_d = S_BLWR;
			S_BLWR, S_LCAP:
				if (cdone)
				begin
					if (st_q == S_LCAP)
					begin
						sup_d[idx_q] = rdat[als_pkg::SUP_BIT];          // [RULE_02]
						ext_d[idx_q] = rdat[als_pkg::EXIT_LSB +: 3];     // [RULE_06]
					end
					idx_d = last ? idx_q : idx_q + IW'(1);
					st_d  = last ? S_DECIDE : S_PTR;
				end
			S_DECIDE:
			begin
				idx_d = '0;
				if (vld_q[0] && sw_q[0] && !sup_q[0])
				begin
					res_d = als_pkg::RES_LINKS;                       // [RULE_03]
					st_d  = S_LRD;
				end
				else if (vld_q[0] && sup_q[0])
					st_d = S_DCAP;                                    // [RULE_04] [RULE_05]
				else
				begin
					res_d = als_pkg::RES_NOEP;                        // [RULE_05]
					st_d  = S_IDLE;
				end
			end
			S_DCAP:
				if (cdone && als_tol_us(rdat[als_pkg::TOL_LSB +: 3]) < als_eff_us(dep_q[idx_q]))
				begin
					tol_d[idx_q] = rdat[als_pkg::TOL_LSB +: 3];       // [RULE_08]
					res_d = als_pkg::RES_LAT;                         // [RULE_09]
					st_d  = S_IDLE;
				end
				else if (!el || cdone)
				begin
					if (cdone)
						tol_d[idx_q] = rdat[als_pkg::TOL_LSB +: 3];   // [RULE_08]
					idx_d = last ? idx_q : idx_q + IW'(1);
					st_d  = last ? S_RRD : S_DCAP;                    // [RULE_09]
				end
			S_RRD:
				if (cdone)
					st_d = S_RWR;
			S_RWR:
				if (cdone)
				begin
					res_d = als_pkg::RES_FULL;
					idx_d = '0;
					st_d  = S_LRD;
				end
			S_LRD:
				if (!el)
				begin
					idx_d = last ? idx_q : idx_q + IW'(1);
					st_d  = last ? S_IDLE : S_LRD;
				end
				else if (cdone)
					st_d = S_LWR;
			S_LWR:
				if (cdone)
				begin
					en_d[idx_q] = 1'b1;
					idx_d = last ? idx_q : idx_q + IW'(1);
					st_d  = last ? S_IDLE : S_LRD;
				end
			default:
				st_d = S_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_q   <= S_IDLE;
			idx_q  <= '0;
			ptr_q  <= 8'h00;
			hop_q  <= 6'h00;
			iss_q  <= 1'b0;
			rsup_q <= 1'b0;
			res_q  <= als_pkg::RES_NONE;
			for (int i = 0; i < NDEV; i++)
			begin
				cap_q[i] <= 8'h00;
				cok_q[i] <= 1'b0;
				sup_q[i] <= 1'b0;
				en_q[i]  <= 1'b0;
				ext_q[i] <= 3'h0;
				tol_q[i] <= 3'h0;
			end
		end
		else
		begin
			st_q   <= st_d;
			idx_q  <= idx_d;
			ptr_q  <= ptr_d;
			hop_q  <= hop_d;
			iss_q  <= iss_d;
			rsup_q <= rsup_d;
			res_q  <= res_d;
			cap_q  <= cap_d;
			cok_q  <= cok_d;
			sup_q  <= sup_d;
			en_q   <= en_d;
			ext_q  <= ext_d;
			tol_q  <= tol_d;
		end
	end

	// ==========================================
	// Register read mux
	// ==========================================
	always_comb
	begin
		case (widx)
			als_pkg::REG_STAT: rd_mux = {27'h0, rsup_q, res_q, busy};
			als_pkg::REG_ROOT: rd_mux = {16'h0000, root_q};
			als_pkg::REG_SEL:  rd_mux = {{(32-IW){1'b0}}, sel_q};
			als_pkg::REG_DCFG: rd_mux = {4'h0, dep_q[sel_q], 1'b0, vld_q[sel_q], bl_q[sel_q],
				sw_q[sel_q], par_q[sel_q], tgt_q[sel_q]};
			als_pkg::REG_DRES: rd_mux = {13'h0, tol_q[sel_q], 1'b0, ext_q[sel_q], 1'b0,
				en_q[sel_q], sup_q[sel_q], cok_q[sel_q], cap_q[sel_q]};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end
endmodule : als_l1_seq

// ### als_l1_seq_sva.sv
`timescale 1ns/100ps
// ==========================================
// Port checker of the sequencer
// ==========================================
module als_l1_seq_sva (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// Config port
	input wire logic        cfg_req_o,
	input wire logic        cfg_we_o,
	input wire logic [11:0] cfg_addr_o,
	input wire logic [31:0] cfg_wdata_o,
	input wire logic        cfg_ack_i
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [11:0] la_q, la_d;	// Address of last completed access
	logic        lw_q, lw_d;	// Last completed access was a write
	// Remember each completion; a write straight after reset has no read to pair with
	always_comb
	begin
		la_d = rst ? 12'h000 : (cfg_ack_i ? cfg_addr_o : la_q);
		lw_d = rst ? 1'b1 : (cfg_ack_i ? cfg_we_o : lw_q);
	end
	always_ff @(posedge mclk)
	begin
		la_q <= la_d;
		lw_q <= lw_d;
	end
	hold_req_a: assert property (cfg_req_o && !cfg_ack_i |=> cfg_req_o && $stable(cfg_addr_o) && $stable(cfg_we_o))
		else $error("config request changed before completion");
	drop_req_a: assert property (cfg_ack_i |=> !cfg_req_o)
		else $error("config request held after completion");
	wdata_hold_a: assert property (cfg_req_o && cfg_we_o && !cfg_ack_i |=> $stable(cfg_wdata_o))
		else $error("write data moved during access");
	rmw_pair_a: assert property ($rose(cfg_req_o) && cfg_we_o |-> !lw_q && la_q == cfg_addr_o)
		else $error("write not preceded by read of same word");
	root_set_a: assert property (cfg_req_o && cfg_we_o && cfg_addr_o == als_pkg::ROOT_LCTL |-> cfg_wdata_o[1])
		else $error("root control write without enable bit");
	cap_read_a: assert property (cfg_req_o && cfg_addr_o == als_pkg::ROOT_LCAP |-> !cfg_we_o)
		else $error("ability word written");
	wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	cover property (cfg_req_o && cfg_we_o && cfg_addr_o == als_pkg::ROOT_LCTL);
	cover property (cfg_ack_i && cfg_we_o);
	cover property (wb_ack_o);
endmodule : als_l1_seq_sva
bind als_l1_seq als_l1_seq_sva i_sva (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .cfg_req_o(cfg_req_o), .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o),
	.cfg_wdata_o(cfg_wdata_o), .cfg_ack_i(cfg_ack_i));

// ### als_cfg_dev.sv
`timescale 1ns/100ps
// ==========================================
// Root port and downstream config spaces
// ==========================================
module als_cfg_dev (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Config port
	input wire logic        req,
	input wire logic        we,
	input wire logic [15:0] tgt,
	input wire logic [11:0] adr,
	input wire logic [31:0] wdat,
	output logic            ack,
	output logic     [31:0] rdat
);
	logic [31:0] mem [logic [27:0]];	// Sparse config words, keyed by target and offset
	logic [2:0]  wt;			// Stall cycles left
	logic        busy;			// Access accepted, not answered
	logic        idle_q;		// Root link parked in electrical idle
	// Root advertises support and a wake delay code
	initial
	begin
		ack = 1'b0;
		rdat = 32'h5a5a_5a5a;
		mem[{16'h0100, 12'h064}] = 32'h0001_0800;
	end
	// Stall depends on offset, so some answers are prompt and some slow
	always @(posedge mclk)
	begin
		ack <= 1'b0;
		rdat <= ~rdat;	// Data is meaningless outside the answer
		// Enabled root link with no access running drops sync and parks
		idle_q <= mem.exists({16'h0100, 12'h068}) && mem[{16'h0100, 12'h068}][1] && !req;
		if (rst)
		begin
			busy <= 1'b0;
			wt <= 3'h0;
		end
		else if (req && !ack)
		begin
			if (!busy)
			begin
				busy <= 1'b1;
				wt <= adr[4:2];
			end
			else if (wt != 3'h0)
				wt <= wt - 3'h1;
			else
			begin
				ack <= 1'b1;
				busy <= 1'b0;
				rdat <= mem.exists({tgt, adr}) ? mem[{tgt, adr}] : 32'hffff_ffff;
				if (we)
					mem[{tgt, adr}] = wdat;
			end
		end
	end
endmodule : als_cfg_dev

// ### als_l1_seq_tb.sv
`timescale 1ns/100ps
// ==========================================
// Sequencer testbench
// ==========================================
module als_l1_seq_tb;
	logic        mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, req, cwe, cack;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, dato, rd, cwd, crd;
	logic [15:0] tgt;
	logic [11:0] cad;
	int          fails = 0, checks = 0, seed = 20;
	always #5 mclk = ~mclk;
	als_l1_seq i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .cfg_req_o(req), .cfg_we_o(cwe),
		.cfg_tgt_o(tgt), .cfg_addr_o(cad), .cfg_wdata_o(cwd), .cfg_ack_i(cack), .cfg_rdata_i(crd));
	als_cfg_dev i_dev (.mclk(mclk), .rst(rst), .req(req), .we(cwe), .tgt(tgt), .adr(cad), .wdat(cwd),
		.ack(cack), .rdat(crd));
	// ==========================================
	// Shared tasks
	// ==========================================
	task close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// One classic cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		rd = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// Loads one function with its capability at 0x40
	task dev(input logic [15:0] t, input logic s, input logic [2:0] c, input logic [31:0] ctl);
		i_dev.mem[{t, 12'h034}] = 32'h40;
		i_dev.mem[{t, 12'h040}] = 32'h10;
		i_dev.mem[{t, 12'h044}] = {20'h0, c, 9'h0};
		i_dev.mem[{t, 12'h04c}] = {14'h0, 3'h5, 3'h0, s, 11'h0};
		i_dev.mem[{t, 12'h050}] = ctl;
	endtask : dev
	function logic tol_ok(input int c, input int d);
		return c == 7 || (1 << c) >= 3 + d;
	endfunction : tol_ok
	// Modes: 0 endpoint, 1 endpoint unsupported, 2 switch unsupported, 3 switch, 4 incompatible below
	task run(input int m);
		int k;
		logic [2:0] c;
		logic ok, en;
		// Corners first: a code too slow for one link, then the unlimited code
		c = checks < 20 ? 3'h1 : checks < 45 ? 3'h7 : 3'($unsigned($random(seed)) % 8);
		ok = tol_ok(c, m == 3 ? 2 : 1);
		en = m == 4 || (m != 1 && m != 2 && ok);
		i_dev.mem[{16'h0100, 12'h068}] = 32'h0;
		dev(16'h0200, m != 1 && m != 2, c, 32'h0);
		dev(16'h0300, 1'b1, c, m == 4 ? 32'h2 : 32'h0);
		wb(1'b1, 8'h08, 32'h0100);
		wb(1'b1, 8'h0c, 32'h0);
		wb(1'b1, 8'h10, {4'h0, 4'h1, 1'b0, 1'b1, 1'b0, m > 1, 4'hf, 16'h0200});
		wb(1'b1, 8'h0c, 32'h1);
		wb(1'b1, 8'h10, m > 2 ? {4'h0, 4'h2, 1'b0, 1'b1, m == 4, 1'b0, 4'h0, 16'h0300} : 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		k = 0;
		do begin wb(1'b0, 8'h04, 32'h0); k++; end while (rd[0] !== 1'b0 && k < 500);
		chk("busy", rd[0], 1'b0);
		chk("result", rd[3:1], m == 1 ? 3 : m == 2 ? 2 : (m == 4 || ok) ? 1 : 4);
		chk("root", i_dev.mem[{16'h0100, 12'h068}][1], en);
		chk("link0", i_dev.mem[{16'h0200, 12'h050}][1], en);
		chk("link1", i_dev.mem[{16'h0300, 12'h050}][1], m == 3 && ok);
		chk("idle", i_dev.idle_q, en);
		wb(1'b1, 8'h0c, 32'h0);
		wb(1'b0, 8'h14, 32'h0);
		chk("wake", rd[14:12], 3'h5);
		chk("support", rd[9], m != 1 && m != 2);
		$display("run mode %0d code %0d done", m, c);
	endtask : run
	// ==========================================
	// Main sequence and watchdog
	// ==========================================
	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		wb(1'b0, 8'h08, 32'h0);
		chk("root id reset", rd, als_pkg::REG_RST);
		wb(1'b0, 8'hfc, 32'h0);
		chk("unmapped", rd, 32'h0);
		for (int i = 0; i < 15; i++)
			run(i % 5);
		close_out();
	end
	initial
	begin
		#500000;
		fails++;
		close_out();
	end
endmodule : als_l1_seq_tb
